// file: include/cfg_access_consts.svh
// Constants of the configuration access message protocol.
// Assumes inclusion by the package and by both channel ends.
`ifndef CFG_ACCESS_CONSTS_SVH
`define CFG_ACCESS_CONSTS_SVH
`define TOK_WRITE 8'hC0
`define TOK_READ 8'hC1
`define TOK_WRITE8 8'hC2
`define TOK_READ8 8'hC3
`define TOK_CLOSE 8'h01
`define TOK_ACK 8'h03
`define TOK_NAK 8'h04
`define DEST_TILE 16'hC20C
`define DEST_NODE 16'hC30C
`define DEST_PERIPH 8'h02
`define PS_TAG 8'h0B
`define PS_SHIFT 8
`define NO_REPLY 8'hFF
`define REG_COUNT 16'h0008
`define RO_MASK 8'h08
`define RESET_WORD 32'h0000_0000
`define MSG_MAX_TOKENS 11
`endif

// file: include/cfg_access_pkg.sv
// Types shared by both channel ends of the configuration access protocol.
// Assumes the constants header is on the include path.
`include "cfg_access_consts.svh"
package cfg_access_pkg;
  typedef enum logic [1:0] {
    BANK_TILE = 2'h0,
    BANK_NODE = 2'h1,
    BANK_PERIPH = 2'h2,
    BANK_PS = 2'h3
  } bank_t;

  typedef logic [8:0] token_t;

  function automatic logic [31:0] make_ps_resid(input logic [23:0] regn);
    make_ps_resid = {regn, 8'h00} | {24'h00_0000, `PS_TAG};
  endfunction : make_ps_resid
endpackage : cfg_access_pkg

// file: include/cfg_chan_if.sv
// Token channel between a requesting channel end and the config handler.
// Each token is a control flag plus one byte; valid/ready per direction.
`timescale 1ns/1ps
interface cfg_chan_if;
  logic req_valid;
  logic req_ctrl;
  logic [7:0] req_data;
  logic [31:0] req_dest;
  logic req_ready;
  logic rsp_valid;
  logic rsp_ctrl;
  logic [7:0] rsp_data;
  logic [23:0] rsp_dest;
  logic rsp_ready;

  modport requester (
    output req_valid, req_ctrl, req_data, req_dest, rsp_ready,
    input req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest
  );
  modport handler (
    input req_valid, req_ctrl, req_data, req_dest, rsp_ready,
    output req_ready, rsp_valid, rsp_ctrl, rsp_data, rsp_dest
  );
endinterface : cfg_chan_if

// file: src/cfg_handler.sv
// Configuration register access handler: decodes token messages from the
// channel, accesses tile, node, peripheral and processor-status banks and
// answers. Assumes the requester holds req_dest for a whole message.
//
// Function
// - Reply goes to the 24-bit reply field
// - Reply low byte all ones suppresses write reply
// - Multi-byte fields travel most significant byte first
// - Status id is register shifted 8, ORed 0x0B
// - Status instructions read and write whole words
// - Tile destination is tile id then C20C
// - Node destination is node id then C30C
// - Peripheral destination is node, peripheral, 02
// - Write: 192, reply, register, data, 1
// - Read: 193, reply, register, 1
// - Write answer: 3,1 success; 4,1 failure
// - Read answer: 3, data, 1; else 4,1
// - Peripheral access in 32-bit or 8-bit widths
`timescale 1ns/1ps
`include "cfg_access_consts.svh"
module cfg_handler #(
  parameter logic [15:0] TILE_ID = 16'h0001,
  parameter logic [15:0] NODE_ID = 16'h0002,
  parameter logic [7:0] PERIPH_ID = 8'h01
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  cfg_chan_if.handler chan,
  input wire logic ps_req_i,
  input wire logic ps_we_i,
  input wire logic [31:0] ps_resid_i,
  input wire logic [31:0] ps_wdata_i,
  output logic ps_done_o,
  output logic ps_err_o,
  output logic [31:0] ps_rdata_o
);
  typedef enum logic [6:0] {
    S_IDLE = 7'h01,
    S_REPLY = 7'h02,
    S_REGN = 7'h04,
    S_DATA = 7'h08,
    S_TAIL = 7'h10,
    S_EXEC = 7'h20,
    S_SEND = 7'h40
  } state_t;

  function automatic logic reg_ok(input logic [15:0] regn,
                                  input logic we);
    // A literal cannot be bit-selected, so the mask goes through a variable
    logic [7:0] ro;
    ro = `RO_MASK;
    reg_ok = (regn < `REG_COUNT) && !(we && ro[regn[2:0]]);
  endfunction : reg_ok

  state_t state_r, state_nxt;
  logic [2:0] cnt_r, cnt_nxt;
  logic wr_r, wr_nxt, byte_r, byte_nxt, err_r, err_nxt;
  logic drop_r, drop_nxt, fin_r, fin_nxt;
  cfg_access_pkg::bank_t bank_r, bank_nxt;
  logic [23:0] reply_r, reply_nxt;
  logic [15:0] regn_r, regn_nxt;
  logic [31:0] wdata_r, wdata_nxt, sdata_r, sdata_nxt;
  logic [31:0] mem_r [4][8];
  logic [31:0] mem_nxt [4][8];
  logic req_ready_r, req_ready_nxt;
  logic rsp_valid_r, rsp_valid_nxt, rsp_ctrl_r, rsp_ctrl_nxt;
  logic [7:0] rsp_data_r, rsp_data_nxt;
  logic [23:0] rsp_dest_r, rsp_dest_nxt;
  logic ps_done_r, ps_done_nxt, ps_err_r, ps_err_nxt;
  logic [31:0] ps_rdata_r, ps_rdata_nxt;
  logic take;
  logic ok;
  logic [31:0] rword;

  assign take = chan.req_valid && req_ready_r;

  //////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    wr_nxt = wr_r;
    byte_nxt = byte_r;
    err_nxt = err_r;
    drop_nxt = drop_r;
    fin_nxt = fin_r;
    bank_nxt = bank_r;
    reply_nxt = reply_r;
    regn_nxt = regn_r;
    wdata_nxt = wdata_r;
    sdata_nxt = sdata_r;
    mem_nxt = mem_r;
    rsp_valid_nxt = rsp_valid_r;
    rsp_ctrl_nxt = rsp_ctrl_r;
    rsp_data_nxt = rsp_data_r;
    rsp_dest_nxt = rsp_dest_r;
    ps_done_nxt = 1'b0;
    ps_err_nxt = ps_err_r;
    ps_rdata_nxt = ps_rdata_r;
    ok = 1'b0;
    rword = 32'h0000_0000;
    case (state_r)
      S_IDLE:
      begin
        if (take && chan.req_ctrl)
        begin
          wr_nxt = (chan.req_data == `TOK_WRITE) ||
                   (chan.req_data == `TOK_WRITE8);
          byte_nxt = (chan.req_data == `TOK_WRITE8) ||
                     (chan.req_data == `TOK_READ8);
          drop_nxt = !(wr_nxt || chan.req_data == `TOK_READ ||
                       chan.req_data == `TOK_READ8);
          err_nxt = 1'b0;
          cnt_nxt = 3'h2;
          state_nxt = drop_nxt ? S_TAIL : S_REPLY;
          if (chan.req_dest[15:0] == `DEST_TILE)
          begin
            bank_nxt = cfg_access_pkg::BANK_TILE;
            err_nxt = chan.req_dest[31:16] != TILE_ID;
          end
          else if (chan.req_dest[15:0] == `DEST_NODE)
          begin
            bank_nxt = cfg_access_pkg::BANK_NODE;
            err_nxt = chan.req_dest[31:16] != NODE_ID;
          end
          else if (chan.req_dest[7:0] == `DEST_PERIPH)
          begin
            bank_nxt = cfg_access_pkg::BANK_PERIPH;
            err_nxt = chan.req_dest[31:16] != NODE_ID ||
                      chan.req_dest[15:8] != PERIPH_ID;
          end
          else
            err_nxt = 1'b1;
          // Width tokens only make sense for a peripheral bank
          if (byte_nxt && bank_nxt != cfg_access_pkg::BANK_PERIPH)
            err_nxt = 1'b1;
        end
        else if (!chan.req_valid && ps_req_i)
        begin
          ok = ps_resid_i[7:0] == `PS_TAG &&
               ps_resid_i[31:24] == 8'h00 &&
               reg_ok(ps_resid_i[23:8], ps_we_i);
          ps_done_nxt = 1'b1;
          ps_err_nxt = !ok;
          ps_rdata_nxt = ok ? mem_r[3][ps_resid_i[10:8]] : 32'h0000_0000;
          if (ok && ps_we_i)
            mem_nxt[3][ps_resid_i[10:8]] = ps_wdata_i;
        end
      end
      S_REPLY, S_REGN, S_DATA:
      begin
        if (take && chan.req_ctrl)
        begin
          // Early close or stray control: fail the message
          err_nxt = 1'b1;
          state_nxt = chan.req_data == `TOK_CLOSE ? S_EXEC : S_TAIL;
        end
        else if (take)
        begin
          cnt_nxt = cnt_r - 3'h1;
          if (state_r == S_REPLY)
            reply_nxt = {reply_r[15:0], chan.req_data};
          else if (state_r == S_REGN)
            regn_nxt = {regn_r[7:0], chan.req_data};
          else
            wdata_nxt = {wdata_r[23:0], chan.req_data};
          if (cnt_r == 3'h0)
          begin
            if (state_r == S_REPLY)
            begin
              state_nxt = S_REGN;
              cnt_nxt = 3'h1;
            end
            else if (state_r == S_REGN && wr_r)
            begin
              state_nxt = S_DATA;
              cnt_nxt = byte_r ? 3'h0 : 3'h3;
            end
            else
              state_nxt = S_TAIL;
          end
        end
      end
      S_TAIL:
      begin
        if (take && chan.req_ctrl && chan.req_data == `TOK_CLOSE)
          state_nxt = S_EXEC;
        else if (take)
          err_nxt = 1'b1;
      end
      S_EXEC:
      begin
        ok = !err_r && reg_ok(regn_r, wr_r);
        rword = mem_r[bank_r][regn_r[2:0]];
        if (ok && wr_r)
          mem_nxt[bank_r][regn_r[2:0]] = byte_r ?
            {rword[31:8], wdata_r[7:0]} : wdata_r;
        sdata_nxt = byte_r ? {rword[7:0], 24'h00_0000} : rword;
        cnt_nxt = (ok && !wr_r) ? (byte_r ? 3'h1 : 3'h4) : 3'h0;
        fin_nxt = 1'b0;
        rsp_dest_nxt = reply_r;
        if (drop_r || (wr_r && reply_r[7:0] == `NO_REPLY))
          state_nxt = S_IDLE;
        else
        begin
          state_nxt = S_SEND;
          rsp_valid_nxt = 1'b1;
          rsp_ctrl_nxt = 1'b1;
          rsp_data_nxt = ok ? `TOK_ACK : `TOK_NAK;
        end
      end
      S_SEND:
      begin
        if (chan.rsp_ready)
        begin
          if (fin_r)
          begin
            rsp_valid_nxt = 1'b0;
            state_nxt = S_IDLE;
          end
          else if (cnt_r != 3'h0)
          begin
            rsp_ctrl_nxt = 1'b0;
            rsp_data_nxt = sdata_r[31:24];
            sdata_nxt = {sdata_r[23:0], 8'h00};
            cnt_nxt = cnt_r - 3'h1;
          end
          else
          begin
            rsp_ctrl_nxt = 1'b1;
            rsp_data_nxt = `TOK_CLOSE;
            fin_nxt = 1'b1;
          end
        end
      end
      default:
        state_nxt = S_IDLE;
    endcase
    // Accept tokens only while collecting a message
    req_ready_nxt = state_nxt == S_IDLE || state_nxt == S_REPLY ||
                    state_nxt == S_REGN || state_nxt == S_DATA ||
                    state_nxt == S_TAIL;
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= S_IDLE;
      cnt_r <= 3'h0;
      wr_r <= 1'b0;
      byte_r <= 1'b0;
      err_r <= 1'b0;
      drop_r <= 1'b0;
      fin_r <= 1'b0;
      bank_r <= cfg_access_pkg::BANK_TILE;
      reply_r <= 24'h00_0000;
      regn_r <= 16'h0000;
      wdata_r <= 32'h0000_0000;
      sdata_r <= 32'h0000_0000;
      for (int b = 0; b < 4; b++)
        for (int i = 0; i < 8; i++)
          mem_r[b][i] <= `RESET_WORD;
      req_ready_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_ctrl_r <= 1'b0;
      rsp_data_r <= 8'h00;
      rsp_dest_r <= 24'h00_0000;
      ps_done_r <= 1'b0;
      ps_err_r <= 1'b0;
      ps_rdata_r <= 32'h0000_0000;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      wr_r <= wr_nxt;
      byte_r <= byte_nxt;
      err_r <= err_nxt;
      drop_r <= drop_nxt;
      fin_r <= fin_nxt;
      bank_r <= bank_nxt;
      reply_r <= reply_nxt;
      regn_r <= regn_nxt;
      wdata_r <= wdata_nxt;
      sdata_r <= sdata_nxt;
      mem_r <= mem_nxt;
      req_ready_r <= req_ready_nxt;
      rsp_valid_r <= rsp_valid_nxt;
      rsp_ctrl_r <= rsp_ctrl_nxt;
      rsp_data_r <= rsp_data_nxt;
      rsp_dest_r <= rsp_dest_nxt;
      ps_done_r <= ps_done_nxt;
      ps_err_r <= ps_err_nxt;
      ps_rdata_r <= ps_rdata_nxt;
    end
  end

  assign chan.req_ready = req_ready_r;
  assign chan.rsp_valid = rsp_valid_r;
  assign chan.rsp_ctrl = rsp_ctrl_r;
  assign chan.rsp_data = rsp_data_r;
  assign chan.rsp_dest = rsp_dest_r;
  assign ps_done_o = ps_done_r;
  assign ps_err_o = ps_err_r;
  assign ps_rdata_o = ps_rdata_r;
endmodule : cfg_handler

// file: src/cfg_requester.sv
// Requesting channel end: turns a user command into a token message and
// collects the answer. Assumes the handler sits on the same clock.
`timescale 1ns/1ps
`include "cfg_access_consts.svh"
module cfg_requester (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  cfg_chan_if.requester chan,
  input wire logic cmd_valid_i,
  input wire cfg_access_pkg::bank_t cmd_bank_i,
  input wire logic cmd_write_i,
  input wire logic cmd_byte_i,
  input wire logic [15:0] cmd_target_i,
  input wire logic [7:0] cmd_periph_i,
  input wire logic [23:0] cmd_reply_i,
  input wire logic [15:0] cmd_regn_i,
  input wire logic [31:0] cmd_wdata_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic ok_o,
  output logic [31:0] rdata_o
);
  typedef enum logic [2:0] {
    H_IDLE = 3'h1,
    H_SEND = 3'h2,
    H_WAIT = 3'h4
  } hstate_t;

  hstate_t state_r, state_nxt;
  cfg_access_pkg::token_t tok_r [11];
  cfg_access_pkg::token_t tok_nxt [11];
  logic [3:0] len_r, len_nxt, idx_r, idx_nxt;
  logic quiet_r, quiet_nxt, ok_r, ok_nxt, done_r, done_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [31:0] dest_r, dest_nxt;
  logic req_valid_r, req_valid_nxt, rsp_ready_r, rsp_ready_nxt;
  logic [7:0] op;

  //////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    state_nxt = state_r;
    tok_nxt = tok_r;
    len_nxt = len_r;
    idx_nxt = idx_r;
    quiet_nxt = quiet_r;
    ok_nxt = ok_r;
    done_nxt = 1'b0;
    rdata_nxt = rdata_r;
    dest_nxt = dest_r;
    req_valid_nxt = req_valid_r;
    op = 8'h00;
    case (state_r)
      H_IDLE:
      begin
        if (cmd_valid_i)
        begin
          op = cmd_write_i ? (cmd_byte_i ? `TOK_WRITE8 : `TOK_WRITE)
                           : (cmd_byte_i ? `TOK_READ8 : `TOK_READ);
          tok_nxt[0] = {1'b1, op};
          for (int i = 0; i < 3; i++)
            tok_nxt[1 + i] = {1'b0, cmd_reply_i[23 - 8 * i -: 8]};
          tok_nxt[4] = {1'b0, cmd_regn_i[15:8]};
          tok_nxt[5] = {1'b0, cmd_regn_i[7:0]};
          for (int i = 0; i < 4; i++)
            tok_nxt[6 + i] = {1'b0, cmd_wdata_i[31 - 8 * i -: 8]};
          if (cmd_write_i && cmd_byte_i)
            tok_nxt[6] = {1'b0, cmd_wdata_i[7:0]};
          len_nxt = !cmd_write_i ? 4'h7 : (cmd_byte_i ? 4'h8 : 4'hB);
          tok_nxt[len_nxt - 4'h1] = {1'b1, `TOK_CLOSE};
          quiet_nxt = cmd_write_i &&
                      cmd_reply_i[7:0] == `NO_REPLY;
          case (cmd_bank_i)
            cfg_access_pkg::BANK_TILE:
              dest_nxt = {cmd_target_i, `DEST_TILE};
            cfg_access_pkg::BANK_NODE:
              dest_nxt = {cmd_target_i, `DEST_NODE};
            default:
              dest_nxt = {cmd_target_i, cmd_periph_i,
                          `DEST_PERIPH};
          endcase
          idx_nxt = 4'h0;
          req_valid_nxt = 1'b1;
          state_nxt = H_SEND;
        end
      end
      H_SEND:
      begin
        if (chan.req_ready)
        begin
          idx_nxt = idx_r + 4'h1;
          if (idx_r == len_r - 4'h1)
          begin
            req_valid_nxt = 1'b0;
            idx_nxt = 4'h0;
            ok_nxt = 1'b0;
            rdata_nxt = 32'h0000_0000;
            state_nxt = quiet_r ? H_IDLE : H_WAIT;
            done_nxt = quiet_r;
            ok_nxt = quiet_r;
          end
        end
      end
      H_WAIT:
      begin
        if (chan.rsp_valid)
        begin
          idx_nxt = idx_r + 4'h1;
          if (chan.rsp_ctrl && chan.rsp_data == `TOK_CLOSE)
          begin
            done_nxt = 1'b1;
            state_nxt = H_IDLE;
          end
          else if (chan.rsp_ctrl)
            ok_nxt = idx_r == 4'h0 && chan.rsp_data == `TOK_ACK;
          else
            rdata_nxt = {rdata_r[23:0], chan.rsp_data};
        end
      end
      default:
        state_nxt = H_IDLE;
    endcase
    rsp_ready_nxt = state_nxt == H_WAIT;
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= H_IDLE;
      for (int i = 0; i < `MSG_MAX_TOKENS; i++)
        tok_r[i] <= 9'h000;
      len_r <= 4'h0;
      idx_r <= 4'h0;
      quiet_r <= 1'b0;
      ok_r <= 1'b0;
      done_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      dest_r <= 32'h0000_0000;
      req_valid_r <= 1'b0;
      rsp_ready_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      tok_r <= tok_nxt;
      len_r <= len_nxt;
      idx_r <= idx_nxt;
      quiet_r <= quiet_nxt;
      ok_r <= ok_nxt;
      done_r <= done_nxt;
      rdata_r <= rdata_nxt;
      dest_r <= dest_nxt;
      req_valid_r <= req_valid_nxt;
      rsp_ready_r <= rsp_ready_nxt;
    end
  end

  assign chan.req_valid = req_valid_r;
  assign chan.req_ctrl = tok_r[idx_r][8];
  assign chan.req_data = tok_r[idx_r][7:0];
  assign chan.req_dest = dest_r;
  assign chan.rsp_ready = rsp_ready_r;
  assign cmd_ready_o = state_r == H_IDLE;
  assign done_o = done_r;
  assign ok_o = ok_r;
  assign rdata_o = rdata_r;
endmodule : cfg_requester

// file: dv/cfg_access_props.sv
// Checker for the token channel that joins requester and handler.
// Assumes one clock domain; sees only the channel signals.
`timescale 1ns/1ps
`include "cfg_access_consts.svh"
module cfg_access_props (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic req_valid,
  input wire logic req_ctrl,
  input wire logic [7:0] req_data,
  input wire logic [31:0] req_dest,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic rsp_ctrl,
  input wire logic [7:0] rsp_data,
  input wire logic [23:0] rsp_dest,
  input wire logic rsp_ready
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] hdr_r;
  logic [3:0] cnt_r;
  logic [23:0] rep_r;
  logic [3:0] rc_r;
  logic ack_r;
  logic req_tk;
  logic rsp_tk;
  logic want;
  assign req_tk = req_valid && req_ready;
  assign rsp_tk = rsp_valid && rsp_ready;
  // Reads always answer; writes stay silent on an all-ones reply byte
  assign want = hdr_r[0] || rep_r[7:0] != `NO_REPLY;
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      hdr_r <= 8'h00;
      cnt_r <= 4'h0;
      rep_r <= 24'h00_0000;
      rc_r <= 4'h0;
      ack_r <= 1'b0;
    end
    else
    begin
      if (req_tk && req_ctrl && req_data >= `TOK_WRITE)
      begin
        hdr_r <= req_data;
        cnt_r <= 4'h0;
      end
      else if (req_tk && !req_ctrl)
      begin
        cnt_r <= cnt_r + 4'h1;
        if (cnt_r < 4'h3)
          rep_r <= {rep_r[15:0], req_data};
      end
      if (rsp_tk && rsp_ctrl && rsp_data == `TOK_ACK)
      begin
        rc_r <= 4'h0;
        ack_r <= 1'b1;
      end
      else if (rsp_tk && !rsp_ctrl)
        rc_r <= rc_r + 4'h1;
      else if (rsp_tk && rsp_ctrl && rsp_data == `TOK_NAK)
        ack_r <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence close_s;
    req_tk && req_ctrl && req_data == `TOK_CLOSE;
  endsequence
  sequence quiet_s;
    !rsp_valid [*8];
  endsequence
  req_hold_a: assert property (req_valid && !req_ready |=>
    req_valid && $stable(req_data) && $stable(req_ctrl) && $stable(req_dest))
    else $error("request token changed before taken");
  rsp_hold_a: assert property (rsp_valid && !rsp_ready |=>
    rsp_valid && $stable(rsp_data) && $stable(rsp_ctrl))
    else $error("reply token changed before taken");
  busy_close_a: assert property (close_s |=> !req_ready)
    else $error("request taken while executing");
  reply_time_a: assert property (close_s ##0 want |->
    ##[2:6] rsp_valid)
    else $error("reply missing after close");
  no_reply_a: assert property (close_s ##0 !want |=> quiet_s)
    else $error("reply sent although suppressed");
  reply_head_a: assert property ($rose(rsp_valid) |-> rsp_ctrl &&
    (rsp_data == `TOK_ACK || rsp_data == `TOK_NAK))
    else $error("reply does not open with 3 or 4");
  nak_close_a: assert property (rsp_tk && rsp_ctrl && rsp_data == `TOK_NAK
    |=> rsp_valid && rsp_ctrl && rsp_data == `TOK_CLOSE)
    else $error("failure reply not closed by 1");
  reply_dest_a: assert property (rsp_valid |->
    rsp_dest == rep_r)
    else $error("reply sent to wrong channel end");
  dest_code_a: assert property (req_tk && req_ctrl && req_data >= `TOK_WRITE
    |-> req_dest[15:0] == `DEST_TILE || req_dest[15:0] == `DEST_NODE ||
    req_dest[7:0] == `DEST_PERIPH)
    else $error("destination code wrong");
  req_len_a: assert property (close_s |-> cnt_r ==
    (hdr_r == `TOK_WRITE ? 4'h9 : hdr_r == `TOK_WRITE8 ? 4'h6 : 4'h5))
    else $error("request field length wrong");
  read_len_a: assert property (rsp_tk && rsp_ctrl && rsp_data == `TOK_CLOSE
    && ack_r |-> rc_r == (hdr_r == `TOK_READ ? 4'h4 :
    hdr_r == `TOK_READ8 ? 4'h1 : 4'h0))
    else $error("reply data length wrong");
endmodule : cfg_access_props

// file: dv/tb_top.sv
// Bench joining requester and handler; a model of the banks checks results.
// Assumes the design's default id parameters are overridden here.
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  fail_count++; $display("CHECK FAILED t=%0t got=%0h exp=%0h", \
  $time, (a), (e)); end end
module tb_top;
  localparam logic [15:0] TID = 16'h0011;
  localparam logic [15:0] NID = 16'h0022;
  localparam logic [7:0] PID = 8'h05;
  logic ref_clk_i, rst_n_i, cmd_valid_i, cmd_write_i, cmd_byte_i;
  cfg_access_pkg::bank_t cmd_bank_i;
  logic [15:0] cmd_target_i, cmd_regn_i;
  logic [7:0] cmd_periph_i;
  logic [23:0] cmd_reply_i;
  logic [31:0] cmd_wdata_i, rdata_o, ps_resid_i, ps_wdata_i, ps_rdata_o, wq;
  logic cmd_ready_o, done_o, ok_o, ps_req_i, ps_we_i, ps_done_o, ps_err_o;
  logic [31:0] mreg [4][8];
  int fail_count, samples_checked, seed;
  logic [31:0] r;
  cfg_chan_if chan_if ();
  cfg_handler #(.TILE_ID(TID), .NODE_ID(NID), .PERIPH_ID(PID)) cfg_handler_i (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .chan(chan_if),
    .ps_req_i(ps_req_i), .ps_we_i(ps_we_i), .ps_resid_i(ps_resid_i),
    .ps_wdata_i(ps_wdata_i), .ps_done_o(ps_done_o), .ps_err_o(ps_err_o),
    .ps_rdata_o(ps_rdata_o));
  cfg_requester cfg_requester_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .chan(chan_if), .cmd_valid_i(cmd_valid_i), .cmd_bank_i(cmd_bank_i),
    .cmd_write_i(cmd_write_i), .cmd_byte_i(cmd_byte_i),
    .cmd_target_i(cmd_target_i), .cmd_periph_i(cmd_periph_i),
    .cmd_reply_i(cmd_reply_i), .cmd_regn_i(cmd_regn_i),
    .cmd_wdata_i(cmd_wdata_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o),
    .ok_o(ok_o), .rdata_o(rdata_o));
  cfg_access_props cfg_access_props_i (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .req_valid(chan_if.req_valid),
    .req_ctrl(chan_if.req_ctrl), .req_data(chan_if.req_data),
    .req_dest(chan_if.req_dest), .req_ready(chan_if.req_ready),
    .rsp_valid(chan_if.rsp_valid), .rsp_ctrl(chan_if.rsp_ctrl),
    .rsp_data(chan_if.rsp_data), .rsp_dest(chan_if.rsp_dest),
    .rsp_ready(chan_if.rsp_ready));
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (fail_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : finish_test
  task automatic bound(input int n, input int lim);
    if (n >= lim)
    begin
      fail_count++;
      finish_test();
    end
  endtask : bound
  // Reply data bytes seen on the wire, assembled most significant first
  always @(posedge ref_clk_i)
  begin
    if (chan_if.rsp_valid && chan_if.rsp_ready && !chan_if.rsp_ctrl)
      wq <= {wq[23:0], chan_if.rsp_data};
  end
  task automatic op(input int bk, input logic w, input logic b,
    input logic [15:0] tg, input logic [7:0] pp, input logic [23:0] rp,
    input logic [15:0] rn, input logic [31:0] wd);
    logic okv;
    logic [31:0] m;
    int n;
    okv = rn < 16'h0008 && !(w && rn == 16'h0003) && (!b || bk == 2) &&
      (bk == 0 ? tg == TID : tg == NID && (bk == 1 || pp == PID));
    m = b ? 32'h0000_00FF : 32'hFFFF_FFFF;
    cmd_valid_i = 1'b1;
    cmd_bank_i = cfg_access_pkg::bank_t'(bk);
    {cmd_write_i, cmd_byte_i, cmd_target_i, cmd_periph_i} = {w, b, tg, pp};
    {cmd_reply_i, cmd_regn_i, cmd_wdata_i} = {rp, rn, wd};
    // Outputs are looked at one step after the edge, never on it
    for (n = 0; n < 50 && cmd_ready_o !== 1'b1; n++)
    begin
      @(posedge ref_clk_i);
      #1;
    end
    bound(n, 50);
    @(posedge ref_clk_i);
    #1;
    cmd_valid_i = 1'b0;
    for (n = 0; n < 300 && done_o !== 1'b1; n++)
    begin
      @(posedge ref_clk_i);
      #1;
    end
    bound(n, 300);
    if (!(w && rp[7:0] == 8'hFF))
      `CHK(ok_o, okv)
    if (okv && !w)
    begin
      `CHK(rdata_o & m, mreg[bk][rn[2:0]] & m)
      `CHK(wq & m, mreg[bk][rn[2:0]] & m)
    end
    if (okv && w)
      mreg[bk][rn[2:0]] = b ? {mreg[bk][rn[2:0]][31:8], wd[7:0]} : wd;
  endtask : op
  task automatic ps(input logic we, input logic [31:0] id,
    input logic [31:0] wd);
    logic okv;
    int n;
    okv = id[31:11] == 21'h0 && !(we && id[10:8] == 3'h3);
    {ps_req_i, ps_we_i, ps_resid_i, ps_wdata_i} = {1'b1, we, id, wd};
    for (n = 0; n < 20 && ps_done_o !== 1'b1; n++)
    begin
      @(posedge ref_clk_i);
      #1;
    end
    bound(n, 20);
    ps_req_i = 1'b0;
    `CHK(ps_err_o, !okv)
    if (okv && !we)
      `CHK(ps_rdata_o, mreg[3][id[10:8]])
    if (okv && we)
      mreg[3][id[10:8]] = wd;
    @(posedge ref_clk_i);
    #1;
  endtask : ps
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  initial
  begin
    logic [15:0] tg;
    {cmd_valid_i, cmd_write_i, cmd_byte_i, ps_req_i, ps_we_i} = 5'h00;
    cmd_bank_i = cfg_access_pkg::BANK_TILE;
    {cmd_target_i, cmd_regn_i, cmd_periph_i, cmd_reply_i} = 64'h0;
    {cmd_wdata_i, ps_resid_i, ps_wdata_i} = 96'h0;
    {fail_count, samples_checked, seed} = {32'h0, 32'h0, 32'd56370};
    foreach (mreg[i, j])
      mreg[i][j] = 32'h0000_0000;
    rst_n_i = 1'b0;
    repeat (16) @(posedge ref_clk_i);
    #1;
    rst_n_i = 1'b1;
    // Reset value, write, read-only, unimplemented, byte, silent, wrong id
    for (int k = 0; k < 3; k++)
    begin
      tg = k == 0 ? TID : NID;
      op(k, 0, 0, tg, PID, 24'h12_3456, 16'h0005, 32'h0);
      op(k, 1, 0, tg, PID, 24'h12_3456, 16'h0005, 32'hA1B2_C3D4);
      op(k, 0, 0, tg, PID, 24'h65_4321, 16'h0005, 32'h0);
      op(k, 1, 0, tg, PID, 24'h12_3456, 16'h0003, 32'h5A5A_0F0F);
      op(k, 0, 0, tg, PID, 24'h12_3456, 16'h0008, 32'h0);
      op(k, 1, 1, tg, PID, 24'h12_3456, 16'h0005, 32'h0000_00E7);
      op(k, 0, 1, tg, PID, 24'h12_3456, 16'h0005, 32'h0);
      op(k, 1, 0, tg, PID, 24'h12_34FF, 16'h0006, 32'h0BAD_F00D);
      op(k, 0, 0, tg, PID, 24'h12_34FF, 16'h0006, 32'h0);
      op(k, 0, 0, 16'h0077, 8'h09, 24'h12_3456, 16'h0001, 32'h0);
    end
    for (int i = 0; i < 60; i++)
    begin
      r = $random(seed);
      tg = r[1:0] == 2'h0 ? TID : NID;
      op(int'(r[1:0]) % 3, r[2], r[3] && r[4], r[16:14] == 3'h7 ?
        16'h00F0 : tg, r[17] && r[18] ? 8'h09 : PID, {16'h2A5C,
        r[13:12] == 2'h0 ? 8'hFF : r[31:24]}, {12'h000, r[9] && r[10],
        r[7:5]}, $random(seed));
    end
    for (int k = 0; k < 8; k++)
    begin
      ps(1, 32'(k << 8) | 32'h0000_000B, $random(seed));
      ps(0, 32'(k << 8) | 32'h0000_000B, 32'h0);
    end
    ps(0, 32'h0000_090B, 32'h0);
    finish_test();
  end
endmodule : tb_top
